/* File: rtl/gfx_decode.sv */
// Graphics instruction group decoder
`timescale 1ns/1ps
// Operation
// - Register forms: source bits 8:5, file select bit 4, destination bits 3:0
// - Upper 1110000x decodes coordinate pair add, one word, 1 cycle, NCZV
// - Upper 1110001x decodes coordinate pair subtract, one word, 1 cycle, NCZV
// - Upper 1110010x decodes coordinate pair compare, 3 cycles, NCZV
// - Upper 1110100x decodes XY to linear convert, 3 cycles, flags untouched
// - Upper 1110110x copies horizontal half, one word, 1 cycle
// - Upper 1110111x copies vertical half, one word, 1 cycle
// - Upper 0x0f with low c0 linear fill, e0 XY fill; XY may set V
// - Upper 0xdf with low Z0011010 is line draw; Z is option; may set V
// - Upper 0x0f low 80/a0 binary source block copy; XY form may set V
// - Upper 0x0f low 00/20 linear source block copy; XY form may set V
// - Upper 0x0f low 40/60 XY source block copy; XY form may set V
// - 1111100x pixel write to linear indirect; 1111000x XY form may set V
// - 1111101x pixel read from linear indirect, minimum 4 cycles
// - 1111001x pixel read from XY indirect, minimum 6 cycles
// - 1111110x linear indirect pixel copy; XY indirect copy may set V
// - Fill, block, draw and pixel write/copy moves have variable length; pixel reads do not
module gfx_decode
	import gfx_decode_pkg::*;
(
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic opcode_valid,
	input wire logic [15:0] opcode,
	output logic dec_valid,
	output gfx_op_t dec_op,
	output logic [3:0] src_reg,
	output logic [3:0] dst_reg,
	output logic file_sel,
	output logic draw_option,
	output logic [1:0] word_count,
	output logic [3:0] min_cycles,
	output logic variable_len,
	output logic [3:0] flags_affected,
	output logic gfx_group,
	output logic unrecognised
);
	wire [7:0] up = opcode[15:8];
	wire [7:0] lo = opcode[7:0];
	wire [6:0] up7 = opcode[15:9];
	wire reg_group = (up[7:4] == 4'he) || (up[7:4] == 4'hf);
	wire array_group = (up == up_array);
	wire line_group = (up == up_line);
	wire in_group = reg_group || array_group || line_group;

	gfx_op_t next_op;
	logic [3:0] next_cyc;
	logic [3:0] next_flags;
	logic next_var;

	always_comb begin
		next_op = op_none;
		next_cyc = cyc_none;
		next_flags = flg_none;
		next_var = 1'b0;
		if (reg_group) begin
			unique case (up7)
				up_add: begin
					next_op = op_coord_pair_add;
					next_cyc = cyc_one;
					next_flags = flg_nczv;
				end
				up_sub: begin
					next_op = op_coord_pair_subtract;
					next_cyc = cyc_one;
					next_flags = flg_nczv;
				end
				up_cmp: begin
					next_op = op_coord_pair_compare;
					next_cyc = cyc_three;
					next_flags = flg_nczv;
				end
				up_window: begin
					next_op = op_window_compare;
					next_cyc = cyc_one;
					next_flags = flg_v;
				end
				up_convert: begin
					next_op = op_coord_to_linear_convert;
					next_cyc = cyc_three;
				end
				up_copy_x: begin
					next_op = op_copy_horizontal_half;
					next_cyc = cyc_one;
				end
				up_copy_y: begin
					next_op = op_copy_vertical_half;
					next_cyc = cyc_one;
				end
				up_pix_wr_lin: begin
					next_op = op_single_pixel_move_wr_lin;
					next_var = 1'b1;
				end
				up_pix_wr_xy: begin
					next_op = op_single_pixel_move_wr_xy;
					next_var = 1'b1;
					next_flags = flg_v;
				end
				up_pix_rd_lin: begin
					next_op = op_single_pixel_move_rd_lin;
					next_cyc = cyc_four;
				end
				up_pix_rd_xy: begin
					next_op = op_single_pixel_move_rd_xy;
					next_cyc = cyc_six;
				end
				up_pix_cp_lin: begin
					next_op = op_single_pixel_move_cp_lin;
					next_var = 1'b1;
				end
				up_pix_cp_xy: begin
					next_op = op_single_pixel_move_cp_xy;
					next_var = 1'b1;
					next_flags = flg_v;
				end
				up_draw_adv: begin
					next_op = op_draw_advance;
					next_var = 1'b1;
					next_flags = flg_v;
				end
				default: next_op = op_none;
			endcase
		end else if (array_group) begin
			next_var = 1'b1;
			unique case (lo)
				lo_fill_lin: next_op = op_fill_linear;
				lo_fill_xy: begin
					next_op = op_fill_xy;
					next_flags = flg_v;
				end
				lo_blt_bin_lin: next_op = op_blk_bin_lin;
				lo_blt_bin_xy: begin
					next_op = op_blk_bin_xy;
					next_flags = flg_v;
				end
				lo_blt_lin_lin: next_op = op_blk_lin_lin;
				lo_blt_lin_xy: begin
					next_op = op_blk_lin_xy;
					next_flags = flg_v;
				end
				lo_blt_xy_lin: next_op = op_blk_xy_lin;
				lo_blt_xy_xy: begin
					next_op = op_blk_xy_xy;
					next_flags = flg_v;
				end
				default: begin
					next_op = op_none;
					next_var = 1'b0;
				end
			endcase
		end else if (line_group && lo[6:0] == lo_line) begin
			next_op = op_line_draw;
			next_var = 1'b1;
			next_flags = flg_v;
		end
	end

	wire next_known = (next_op != op_none);
	wire next_unrec = in_group && !next_known;
	wire has_regs = reg_group && next_known;

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			dec_valid <= 1'b0;
			dec_op <= op_none;
			src_reg <= 4'h0;
			dst_reg <= 4'h0;
			file_sel <= 1'b0;
			draw_option <= 1'b0;
			word_count <= 2'h0;
			min_cycles <= cyc_none;
			variable_len <= 1'b0;
			flags_affected <= flg_none;
			gfx_group <= 1'b0;
			unrecognised <= 1'b0;
		end else begin
			dec_valid <= opcode_valid && next_known;
			gfx_group <= opcode_valid && in_group;
			unrecognised <= opcode_valid && next_unrec;
			if (opcode_valid) begin
				dec_op <= next_op;
				src_reg <= has_regs ? opcode[8:5] : 4'h0;
				file_sel <= has_regs ? opcode[4] : 1'b0;
				dst_reg <= has_regs ? opcode[3:0] : 4'h0;
				draw_option <= (next_op == op_line_draw) ? lo[7] : 1'b0;
				word_count <= next_known ? 2'h1 : 2'h0;
				min_cycles <= next_cyc;
				variable_len <= next_var;
				flags_affected <= next_flags;
			end
		end
	end
endmodule

/* File: rtl/gfx_decode_pkg.sv */
// Constants and types for the graphics instruction decoder
package gfx_decode_pkg;
	// Upper byte patterns with the source extension bit masked off
	localparam logic [6:0] up_add = 7'h70;
	localparam logic [6:0] up_sub = 7'h71;
	localparam logic [6:0] up_cmp = 7'h72;
	localparam logic [6:0] up_window = 7'h73;
	localparam logic [6:0] up_convert = 7'h74;
	localparam logic [6:0] up_copy_x = 7'h76;
	localparam logic [6:0] up_copy_y = 7'h77;
	localparam logic [6:0] up_pix_wr_xy = 7'h78;
	localparam logic [6:0] up_pix_rd_xy = 7'h79;
	localparam logic [6:0] up_pix_cp_xy = 7'h7a;
	localparam logic [6:0] up_draw_adv = 7'h7b;
	localparam logic [6:0] up_pix_wr_lin = 7'h7c;
	localparam logic [6:0] up_pix_rd_lin = 7'h7d;
	localparam logic [6:0] up_pix_cp_lin = 7'h7e;
	// Full upper byte for array and line opcodes
	localparam logic [7:0] up_array = 8'h0f;
	localparam logic [7:0] up_line = 8'hdf;
	// Low byte patterns
	localparam logic [7:0] lo_fill_lin = 8'hc0;
	localparam logic [7:0] lo_fill_xy = 8'he0;
	localparam logic [7:0] lo_blt_bin_lin = 8'h80;
	localparam logic [7:0] lo_blt_bin_xy = 8'ha0;
	localparam logic [7:0] lo_blt_lin_lin = 8'h00;
	localparam logic [7:0] lo_blt_lin_xy = 8'h20;
	localparam logic [7:0] lo_blt_xy_lin = 8'h40;
	localparam logic [7:0] lo_blt_xy_xy = 8'h60;
	localparam logic [6:0] lo_line = 7'h1a;
	// Minimum cycle counts
	localparam logic [3:0] cyc_one = 4'h1;
	localparam logic [3:0] cyc_three = 4'h3;
	localparam logic [3:0] cyc_four = 4'h4;
	localparam logic [3:0] cyc_six = 4'h6;
	localparam logic [3:0] cyc_none = 4'h0;
	// Flag mask bits: negative, carry, zero, overflow
	localparam logic [3:0] flg_nczv = 4'hf;
	localparam logic [3:0] flg_v = 4'h1;
	localparam logic [3:0] flg_none = 4'h0;

	typedef enum logic [4:0] {
		op_none = 5'b00000,
		op_coord_pair_add = 5'b00001,
		op_coord_pair_subtract = 5'b00010,
		op_coord_pair_compare = 5'b00011,
		op_window_compare = 5'b00100,
		op_coord_to_linear_convert = 5'b00101,
		op_copy_horizontal_half = 5'b00110,
		op_copy_vertical_half = 5'b00111,
		op_fill_linear = 5'b01000,
		op_fill_xy = 5'b01001,
		op_line_draw = 5'b01010,
		op_draw_advance = 5'b01011,
		op_blk_bin_lin = 5'b01100,
		op_blk_bin_xy = 5'b01101,
		op_blk_lin_lin = 5'b01110,
		op_blk_lin_xy = 5'b01111,
		op_blk_xy_lin = 5'b10000,
		op_blk_xy_xy = 5'b10001,
		op_single_pixel_move_wr_lin = 5'b10010,
		op_single_pixel_move_wr_xy = 5'b10011,
		op_single_pixel_move_rd_lin = 5'b10100,
		op_single_pixel_move_rd_xy = 5'b10101,
		op_single_pixel_move_cp_lin = 5'b10110,
		op_single_pixel_move_cp_xy = 5'b10111
	} gfx_op_t;
endpackage

/* File: verification/fetch_model.sv */
// Fetch unit model presenting opcode words to the decoder
`timescale 1ns/1ps
module fetch_model (
	input wire logic clk_sys,
	input wire logic push,
	input wire logic [15:0] word,
	output logic opcode_valid,
	output logic [15:0] opcode);
	// Idle bus shows the inverse of the last word
	assign opcode_valid = push;
	assign opcode = push ? word : ~word;
endmodule

/* File: verification/gfx_decode_monitor.sv */
// Checker bound to the graphics decoder
`timescale 1ns/1ps
module gfx_decode_monitor
	import gfx_decode_pkg::*; (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic opcode_valid,
	input wire logic [15:0] opcode,
	input wire logic dec_valid,
	input wire gfx_op_t dec_op,
	input wire logic [3:0] src_reg,
	input wire logic [3:0] dst_reg,
	input wire logic draw_option,
	input wire logic [3:0] min_cycles,
	input wire logic [3:0] flags_affected,
	input wire logic unrecognised);
	wire logic [6:0] up = opcode_valid ? opcode[15:9] : 7'h00;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!arst_n);
	AST_ADD: assert property (up == up_add |=> dec_op == op_coord_pair_add)
		else $error("add decode");
	AST_FIELDS: assert property (up == up_sub |=> src_reg == $past(opcode[8:5])
		&& dst_reg == $past(opcode[3:0])) else $error("fields");
	AST_CMP: assert property (up == up_cmp |=> min_cycles == cyc_three
		&& flags_affected == flg_nczv) else $error("compare");
	AST_CONV: assert property (up == up_convert |=> min_cycles == cyc_three
		&& flags_affected == flg_none) else $error("convert");
	AST_RD_LIN: assert property (up == up_pix_rd_lin |=> dec_valid
		&& min_cycles == cyc_four) else $error("read linear");
	AST_RD_XY: assert property (up == up_pix_rd_xy |=> dec_valid
		&& min_cycles == cyc_six) else $error("read xy");
	AST_LINE: assert property (opcode_valid && opcode[15:8] == up_line
		&& opcode[6:0] == lo_line |=> draw_option == $past(opcode[7])) else $error("line");
	AST_REFUSE: assert property (unrecognised |-> !dec_valid
		&& dec_op == op_none) else $error("refuse");
	COV_LINE: cover property (dec_op == op_line_draw);
	COV_UNREC: cover property (unrecognised);
	COV_B2B: cover property (dec_valid ##1 unrecognised);
endmodule
bind gfx_decode gfx_decode_monitor gfx_decode_monitor_inst (.*);

/* File: verification/testbench.sv */
// Self-checking bench for the graphics decoder
`timescale 1ns/1ps
`define CK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; \
	$display("Error %0t %h %h", $time, a, b); end end
module testbench;
	import gfx_decode_pkg::*;
	logic clk_sys = 0, arst_n = 0, push = 0, opcode_valid, dec_valid, file_sel;
	logic draw_option, variable_len, gfx_group, unrecognised;
	logic [15:0] word = 16'h0000, opcode;
	logic [3:0] src_reg, dst_reg, min_cycles, flags_affected;
	logic [1:0] word_count;
	gfx_op_t dec_op;
	int num_errors = 0, total_checks = 0;
	always #12.5 clk_sys = ~clk_sys;
	fetch_model fetch_model_inst (.*);
	gfx_decode gfx_decode_inst (.*);
	task give_verdict;
		if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task go(input logic [15:0] w, input gfx_op_t op, input logic [3:0] mc, fl);
		@(posedge clk_sys);
		push <= 1'b1;
		word <= w;
		@(posedge clk_sys);
		push <= 1'b0;
		@(negedge clk_sys);
		`CK({dec_valid, gfx_group, dec_op, min_cycles, flags_affected, variable_len},
			{2'b11, op, mc, fl, mc == 4'h0})
		`CK({src_reg, file_sel, dst_reg, word_count}, {w[15:13] == 3'h7 ? w[8:0] : 9'h000, 2'h1})
		`CK(draw_option, op == op_line_draw && w[7])
	endtask
	task t_decode;
		go(16'he1b5, op_coord_pair_add, 4'h1, 4'hf);
		go(16'he3b5, op_coord_pair_subtract, 4'h1, 4'hf);
		go(16'he400, op_coord_pair_compare, 4'h3, 4'hf);
		go(16'he9ff, op_coord_to_linear_convert, 4'h3, 4'h0);
		go(16'hec12, op_copy_horizontal_half, 4'h1, 4'h0);
		go(16'hef12, op_copy_vertical_half, 4'h1, 4'h0);
		go(16'he7a3, op_window_compare, 4'h1, 4'h1);
		go(16'hf6a3, op_draw_advance, 4'h0, 4'h1);
		go(16'h0fc0, op_fill_linear, 4'h0, 4'h0);
		go(16'h0fe0, op_fill_xy, 4'h0, 4'h1);
		go(16'h0f80, op_blk_bin_lin, 4'h0, 4'h0);
		go(16'h0fa0, op_blk_bin_xy, 4'h0, 4'h1);
		go(16'h0f00, op_blk_lin_lin, 4'h0, 4'h0);
		go(16'h0f20, op_blk_lin_xy, 4'h0, 4'h1);
		go(16'h0f40, op_blk_xy_lin, 4'h0, 4'h0);
		go(16'h0f60, op_blk_xy_xy, 4'h0, 4'h1);
		go(16'hdf9a, op_line_draw, 4'h0, 4'h1);
	endtask
	task t_pixel;
		go(16'hf812, op_single_pixel_move_wr_lin, 4'h0, 4'h0);
		go(16'hf012, op_single_pixel_move_wr_xy, 4'h0, 4'h1);
		go(16'hf212, op_single_pixel_move_rd_xy, 4'h6, 4'h0);
		go(16'hfc12, op_single_pixel_move_cp_lin, 4'h0, 4'h0);
		go(16'hf412, op_single_pixel_move_cp_xy, 4'h0, 4'h1);
		@(posedge clk_sys);
		push <= 1'b1;
		word <= 16'hfa12;
		@(posedge clk_sys);
		word <= 16'h0f10;
		@(negedge clk_sys);
		`CK({dec_valid, min_cycles}, 5'h14)
		@(posedge clk_sys);
		push <= 1'b0;
		@(negedge clk_sys);
		`CK({unrecognised, dec_valid, dec_op}, {2'b10, op_none})
	endtask
	initial begin
		repeat (16) @(posedge clk_sys);
		arst_n <= 1'b1;
		t_decode;
		t_pixel;
		give_verdict;
	end
	initial #20us begin
		num_errors++;
		give_verdict;
	end
endmodule
